// [rtl/sdv_step_drive.sv]
// sdv_step_drive: control logic of a step motor drive
// assumes pins arrive asynchronous, analog samples come from a 12-bit converter
// Operation
// - steps-per-rev pulses make exactly one motor revolution
// - enable-when-closed energises motor while input closed
// - enable-when-open energises motor while input open
// - alarm reset clears latched fault on chosen input edge
// - unassigned input state stays readable by status queries
// - fault output closes, or opens inverted, while fault present
// - brake output releases brake with selectable polarity
// - motion output closed, or open inverted, while moving
// - tach output pulses with motor position advance
// - unassigned output set, raised or lowered by host commands
// - velocity run/stop runs while pulse input closed
// - without run/stop run always, zero analog gives no motion
// - velocity direction from rotation-sense input, flipped by analog sign below offset when offset enabled
// - fixed speed with separate accel and decel ramps
// - analog speed linear, maximum at full-scale input
// - nonzero offset is zero speed, bidirectional, half max speed
// - deadband window around zero or offset holds motor stopped
// - 12-bit analog filtered by configurable low-pass
// - speed-change input selects alternate speed while closed
// - single-character address, up to 32 drives per link
// - reply waits configurable transmit delay; host drops driver
// - pulse mode speed from pulses, direction from level
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module sdv_step_drive
  import sdv_pkg::*;
#(
  parameter int CLK_HZ = SDV_CLK_HZ
) (
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // sync reset, high
  input wire sdv_pkg::sdv_avm_req_t avm, // avalon request
  output logic avmWaitrequest, // avalon wait
  output logic [31:0] avmReaddata, // avalon read data
  input wire logic pulsePin, // step / run-stop pin
  input wire logic dirPin, // rotation sense pin
  input wire logic gatePin, // motor-gate pin, high = closed
  input wire logic [11:0] analogSample, // converter sample
  input wire logic analogValid, // sample strobe
  input wire logic faultIn, // fault condition from power stage
  input wire logic moving, // motor moving flag
  input wire logic replyReq, // serial reply ready
  output logic txEnable, // serial driver enable
  output logic outPin, // output, high = closed
  output logic motorEnable, // energise motor
  output sdv_pkg::sdv_step_t motorStep, // step request
  output logic [15:0] stepsRevCount // position within revolution
);
  sdv_ctrl_t ctrl_reg;
  logic [15:0] stepsRev_reg, speed_reg, altSpeed_reg, accel_reg, decel_reg;
  logic [11:0] offset_reg, deadband_reg;
  logic [3:0] filtShift_reg;
  logic [7:0] addr_reg;
  logic [15:0] txDelay_reg;
  logic outSw_reg, faultLatch_reg, tach_reg, rdValid_reg;
  logic [31:0] revs_reg;
  logic [2:0] pulseSync, dirSync, gateSync;
  logic [23:0] filt_reg;
  logic [31:0] txCnt_reg;
  logic gate, gatePrev, pulse, pulsePrev, dir;
  logic alarmClear;
  logic [11:0] filtVal, mag;
  logic magNeg;
  logic [27:0] anaProd;
  logic [15:0] velTarget, velCur;
  logic velTick, velRun, wr, rd;
  sdv_step_t stepNext;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } sdv_tx_t;
  sdv_tx_t tx_reg;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pulseSync <= 3'h0;
      dirSync <= 3'h0;
      gateSync <= 3'h0;
    end else begin
      pulseSync <= {pulseSync[1:0], pulsePin};
      dirSync <= {dirSync[1:0], dirPin};
      gateSync <= {gateSync[1:0], gatePin};
    end
  end
  assign pulse = pulseSync[1];
  assign pulsePrev = pulseSync[2];
  assign gate = gateSync[1];
  assign gatePrev = gateSync[2];
  assign dir = dirSync[1] ^ ctrl_reg.cwPolarity;

  // ---------------------------------------------------------------
  // avalon slave, one wait state on reads
  // ---------------------------------------------------------------
  // read data registered first, then released with waitrequest low
  assign avmWaitrequest = rd && !rdValid_reg;
  assign wr = avm.write;
  assign rd = avm.read;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= '0;
      stepsRev_reg <= SDV_RST_STEPS_REV;
      speed_reg <= SDV_RST_SPEED;
      altSpeed_reg <= SDV_RST_SPEED;
      accel_reg <= SDV_RST_ACCEL;
      decel_reg <= SDV_RST_ACCEL;
      offset_reg <= 12'h000;
      deadband_reg <= SDV_RST_DEADBAND;
      filtShift_reg <= SDV_RST_FILT_SHIFT;
      addr_reg <= SDV_RST_ADDR;
      txDelay_reg <= SDV_RST_TXDLY_MS;
    end else if (wr) begin
      case (avm.address)
        SDV_OFS_CTRL: ctrl_reg <= avm.writedata;
        SDV_OFS_STEPS_REV: stepsRev_reg <= avm.writedata[15:0];
        SDV_OFS_SPEED: speed_reg <= avm.writedata[15:0];
        SDV_OFS_ALT_SPEED: altSpeed_reg <= avm.writedata[15:0];
        SDV_OFS_ACCEL: accel_reg <= avm.writedata[15:0];
        SDV_OFS_DECEL: decel_reg <= avm.writedata[15:0];
        SDV_OFS_ANALOG: begin
          offset_reg <= avm.writedata[11:0];
          deadband_reg <= avm.writedata[27:16];
        end
        SDV_OFS_FILTER: filtShift_reg <= avm.writedata[3:0];
        SDV_OFS_SERIAL: begin
          addr_reg <= avm.writedata[7:0];
          txDelay_reg <= avm.writedata[31:16];
        end
        default: ;
      endcase
    end
  end

  // host output commands, drive / high / low
  always_ff @(posedge clk) begin
    if (rst) begin
      outSw_reg <= 1'b0;
    end else if (wr && avm.address == SDV_OFS_OUTCMD) begin
      case (sdv_out_cmd_t'(avm.writedata[1:0]))
        SDV_OCMD_DRIVE: outSw_reg <= avm.writedata[4];
        SDV_OCMD_HIGH: outSw_reg <= 1'b1;
        SDV_OCMD_LOW: outSw_reg <= 1'b0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avmReaddata <= 32'h00000000;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= rd && !rdValid_reg;
      if (rd && !rdValid_reg) begin
        case (avm.address)
          SDV_OFS_CTRL: avmReaddata <= ctrl_reg;
          SDV_OFS_STEPS_REV: avmReaddata <= {16'h0000, stepsRev_reg};
          SDV_OFS_SPEED: avmReaddata <= {16'h0000, speed_reg};
          SDV_OFS_ALT_SPEED: avmReaddata <= {16'h0000, altSpeed_reg};
          SDV_OFS_ACCEL: avmReaddata <= {16'h0000, accel_reg};
          SDV_OFS_DECEL: avmReaddata <= {16'h0000, decel_reg};
          SDV_OFS_ANALOG: avmReaddata <= {4'h0, deadband_reg, 4'h0, offset_reg};
          SDV_OFS_FILTER: avmReaddata <= {28'h0000000, filtShift_reg};
          SDV_OFS_SERIAL: avmReaddata <= {txDelay_reg, 8'h00, addr_reg};
          SDV_OFS_OUTCMD: avmReaddata <= {31'h00000000, outSw_reg};
          // input status query: gate, dir, pulse levels
          SDV_OFS_STATUS: avmReaddata <= {velCur, 8'h00, 2'h0, motorEnable, outPin,
                                          faultLatch_reg, gate, dirSync[1], pulse};
          SDV_OFS_POSITION: avmReaddata <= {16'h0000, stepsRevCount};
          SDV_OFS_REVS: avmReaddata <= revs_reg;
          SDV_OFS_FAULT: avmReaddata <= {31'h00000000, faultLatch_reg};
          SDV_OFS_TXGO: avmReaddata <= {29'h00000000, tx_reg};
          default: avmReaddata <= SDV_UNMAPPED;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // alarm latch and reset on gate edge
  // ---------------------------------------------------------------
  assign alarmClear = (ctrl_reg.gateFn == SDV_EN_RST_CLOSE && gate && !gatePrev)
                   || (ctrl_reg.gateFn == SDV_EN_RST_OPEN && !gate && gatePrev);
  always_ff @(posedge clk) begin
    if (rst) begin
      faultLatch_reg <= 1'b0;
    end else if (faultIn) begin
      faultLatch_reg <= 1'b1; // set wins over clear
    end else if (alarmClear || (wr && avm.address == SDV_OFS_FAULT && avm.writedata[0])) begin
      faultLatch_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // motor enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      motorEnable <= 1'b0;
    end else begin
      case (ctrl_reg.gateFn)
        SDV_EN_CLOSED: motorEnable <= gate && !faultLatch_reg;
        SDV_EN_OPEN: motorEnable <= !gate && !faultLatch_reg;
        default: motorEnable <= !faultLatch_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // analog filter, deadband, offset and scaling
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_reg <= 24'h000000;
    end else if (analogValid) begin
      // first-order low-pass, cutoff set by shift
      filt_reg <= filt_reg - (filt_reg >> filtShift_reg) + {12'h000, analogSample};
    end
  end
  assign filtVal = 12'(filt_reg >> filtShift_reg);

  always_comb begin
    magNeg = 1'b0;
    mag = filtVal;
    if (ctrl_reg.analogOffsetEn) begin
      magNeg = filtVal < offset_reg;
      mag = magNeg ? offset_reg - filtVal : filtVal - offset_reg;
    end
    if (mag <= deadband_reg) begin
      mag = 12'h000;
    end
  end
  // linear scale, full scale 4095 gives configured speed half with offset
  assign anaProd = {12'h000, speed_reg} * {16'h0000, mag};
  always_comb begin
    velTarget = 16'(anaProd / 28'hfff);
    if (ctrl_reg.analogOffsetEn && velTarget > (speed_reg >> 1)) begin
      velTarget = speed_reg >> 1;
    end
    if (!ctrl_reg.analogEn) begin
      velTarget = (ctrl_reg.gateFn == SDV_EN_SPEED && gate) ? altSpeed_reg : speed_reg;
    end
    velRun = ctrl_reg.runStopEn ? pulse : 1'b1;
    if (!velRun || ctrl_reg.mode != SDV_MODE_VEL) begin
      velTarget = 16'h0000;
    end
  end

  sdv_vel_gen #(
    .CLK_HZ(CLK_HZ)
  ) u_vel (
    .clk(clk),
    .rst(rst),
    .targetSpeed(velTarget),
    .accelRate(accel_reg),
    .decelRate(decel_reg),
    .curSpeed(velCur),
    .stepPulse(velTick)
  );

  // ---------------------------------------------------------------
  // step selection and position
  // ---------------------------------------------------------------
  always_comb begin
    stepNext.dirCw = dir;
    if (ctrl_reg.mode == SDV_MODE_VEL) begin
      stepNext.step = velTick;
      if (ctrl_reg.analogOffsetEn && ctrl_reg.analogEn) begin
        stepNext.dirCw = dir ^ magNeg;
      end
    end else begin
      stepNext.step = pulse && !pulsePrev;
    end
    if (!motorEnable) begin
      stepNext.step = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      motorStep <= '0;
      stepsRevCount <= 16'h0000;
      revs_reg <= 32'h00000000;
      tach_reg <= 1'b0;
    end else begin
      motorStep <= stepNext;
      if (stepNext.step) begin
        tach_reg <= !tach_reg;
        if (stepsRevCount >= stepsRev_reg - 16'h0001) begin
          stepsRevCount <= 16'h0000;
          revs_reg <= revs_reg + 32'h00000001;
        end else begin
          stepsRevCount <= stepsRevCount + 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // output function
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      outPin <= 1'b0;
    end else begin
      case (ctrl_reg.outFn)
        SDV_OUT_FAULT: outPin <= faultLatch_reg ^ ctrl_reg.outInvert;
        SDV_OUT_BRAKE: outPin <= motorEnable ^ ctrl_reg.outInvert;
        SDV_OUT_MOTION: outPin <= moving ^ ctrl_reg.outInvert;
        SDV_OUT_TACH: outPin <= tach_reg;
        default: outPin <= outSw_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // transmit turnaround delay
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_reg <= TX_IDLE;
      txCnt_reg <= 32'h00000000;
    end else begin
      case (tx_reg)
        TX_IDLE: if (replyReq) begin
          tx_reg <= TX_WAIT;
          txCnt_reg <= 32'(txDelay_reg) * 32'(CLK_HZ / SDV_MS_PER_S);
        end
        TX_WAIT: if (txCnt_reg == 32'h00000000) begin
          tx_reg <= TX_SEND;
        end else begin
          txCnt_reg <= txCnt_reg - 32'h00000001;
        end
        TX_SEND: if (!replyReq) begin
          tx_reg <= TX_IDLE;
        end
        default: tx_reg <= TX_IDLE;
      endcase
    end
  end
  assign txEnable = (tx_reg == TX_SEND);
endmodule

// [rtl/sdv_pkg.sv]
// sdv_pkg: shared constants, register map and types of the step drive control block
// assumes a single 25 MHz clock and an Avalon-MM register slave
package sdv_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SDV_OFS_CTRL = 8'h00;
  localparam logic [7:0] SDV_OFS_STEPS_REV = 8'h04;
  localparam logic [7:0] SDV_OFS_SPEED = 8'h08;
  localparam logic [7:0] SDV_OFS_ALT_SPEED = 8'h0c;
  localparam logic [7:0] SDV_OFS_ACCEL = 8'h10;
  localparam logic [7:0] SDV_OFS_DECEL = 8'h14;
  localparam logic [7:0] SDV_OFS_ANALOG = 8'h18;
  localparam logic [7:0] SDV_OFS_FILTER = 8'h1c;
  localparam logic [7:0] SDV_OFS_SERIAL = 8'h20;
  localparam logic [7:0] SDV_OFS_OUTCMD = 8'h24;
  localparam logic [7:0] SDV_OFS_STATUS = 8'h28;
  localparam logic [7:0] SDV_OFS_POSITION = 8'h2c;
  localparam logic [7:0] SDV_OFS_REVS = 8'h30;
  localparam logic [7:0] SDV_OFS_FAULT = 8'h34;
  localparam logic [7:0] SDV_OFS_TXGO = 8'h38;
  localparam logic [31:0] SDV_UNMAPPED = 32'hdeadbeef;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SDV_RST_STEPS_REV = 16'h4e20;
  localparam logic [15:0] SDV_RST_SPEED = 16'h0064;
  localparam logic [15:0] SDV_RST_ACCEL = 16'h0064;
  localparam logic [11:0] SDV_RST_DEADBAND = 12'h029;
  localparam logic [3:0] SDV_RST_FILT_SHIFT = 4'h4;
  localparam logic [7:0] SDV_RST_ADDR = 8'h31;
  localparam logic [15:0] SDV_RST_TXDLY_MS = 16'h000a;
  localparam int SDV_MAX_DROPS = 32;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SDV_CLK_HZ = 25000000;
  localparam int SDV_MS_PER_S = 1000;
  localparam int SDV_CYC_PER_MS = SDV_CLK_HZ / SDV_MS_PER_S;

  // ---------------------------------------------------------------
  // function selectors
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SDV_EN_NONE = 3'h0,
    SDV_EN_CLOSED = 3'h1,
    SDV_EN_OPEN = 3'h2,
    SDV_EN_RST_CLOSE = 3'h3,
    SDV_EN_RST_OPEN = 3'h4,
    SDV_EN_SPEED = 3'h5
  } sdv_gate_fn_t;

  typedef enum logic [2:0] {
    SDV_OUT_NONE = 3'h0,
    SDV_OUT_FAULT = 3'h1,
    SDV_OUT_BRAKE = 3'h2,
    SDV_OUT_MOTION = 3'h3,
    SDV_OUT_TACH = 3'h4
  } sdv_out_fn_t;

  typedef enum logic [1:0] {
    SDV_MODE_PULSE = 2'h0,
    SDV_MODE_VEL = 2'h1,
    SDV_MODE_HOST = 2'h2
  } sdv_mode_t;

  // host-side output commands
  typedef enum logic [1:0] {
    SDV_OCMD_DRIVE = 2'h0,
    SDV_OCMD_HIGH = 2'h1,
    SDV_OCMD_LOW = 2'h2
  } sdv_out_cmd_t;

  // control register fields
  typedef struct packed {
    logic [14:0] spare;
    logic analogOffsetEn;
    logic analogEn;
    logic runStopEn;
    logic cwPolarity;
    logic outInvert;
    sdv_out_fn_t outFn;
    sdv_gate_fn_t gateFn;
    sdv_mode_t mode;
    logic [3:0] spare2;
  } sdv_ctrl_t;

  // motion step request to the phase sequencer
  typedef struct packed {
    logic step;
    logic dirCw;
  } sdv_step_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } sdv_avm_req_t;
endpackage

// [rtl/sdv_vel_gen.sv]
// sdv_vel_gen: speed ramp and step-rate generator
// assumes target speed in steps per second and rates in steps per second per millisecond
`timescale 1ns/10ps
module sdv_vel_gen #(
  parameter int CLK_HZ = 25000000
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic [15:0] targetSpeed, // steps per second wanted
  input wire logic [15:0] accelRate, // speed rise per ms
  input wire logic [15:0] decelRate, // speed fall per ms
  output logic [15:0] curSpeed, // present speed
  output logic stepPulse // one-cycle step tick
);
  localparam int MS_CYC = CLK_HZ / 1000;
  logic [31:0] phaseReg;
  logic [15:0] msCntReg;
  logic [16:0] sumUp;
  logic [31:0] phaseNext;

  // ---------------------------------------------------------------
  // ramp once a millisecond
  // ---------------------------------------------------------------
  assign sumUp = {1'b0, curSpeed} + {1'b0, accelRate};
  always_ff @(posedge clk) begin
    if (rst) begin
      msCntReg <= 16'h0000;
      curSpeed <= 16'h0000;
    end else if (msCntReg == 16'(MS_CYC - 1)) begin
      msCntReg <= 16'h0000;
      if (curSpeed < targetSpeed) begin
        curSpeed <= (sumUp > {1'b0, targetSpeed}) ? targetSpeed : sumUp[15:0];
      end else if (curSpeed > targetSpeed) begin
        curSpeed <= (curSpeed - targetSpeed < decelRate) ? targetSpeed : curSpeed - decelRate;
      end
    end else begin
      msCntReg <= msCntReg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // step rate accumulator
  // ---------------------------------------------------------------
  assign phaseNext = phaseReg + {16'h0000, curSpeed};
  always_ff @(posedge clk) begin
    if (rst) begin
      phaseReg <= 32'h00000000;
      stepPulse <= 1'b0;
    end else if (phaseNext >= 32'(CLK_HZ)) begin
      phaseReg <= phaseNext - 32'(CLK_HZ);
      stepPulse <= 1'b1;
    end else begin
      phaseReg <= phaseNext;
      stepPulse <= 1'b0;
    end
  end
endmodule

// [test/sdv_step_drive_asserts.sv]
// sdv_step_drive_asserts: port checks of the step drive
// assumes it is bound into each sdv_step_drive
`timescale 1ns/10ps
module sdv_step_drive_asserts
  import sdv_pkg::*;
#(
  parameter int CLK_HZ = SDV_CLK_HZ
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire sdv_pkg::sdv_avm_req_t avm, // bus request
  input wire logic avmWaitrequest, // bus wait
  input wire logic gatePin, // gate pin
  input wire logic faultIn, // fault level
  input wire logic replyReq, // reply pending
  input wire logic txEnable, // driver enable
  input wire logic outPin, // output pin
  input wire logic motorEnable, // energise
  input wire sdv_pkg::sdv_step_t motorStep // step request
);
  // ------
  // shadow of the control word
  // ------
  sdv_ctrl_t ctrlReg;
  logic [3:0] age;
  logic ok;
  assign ok = age > 4'h6;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlReg <= '0;
      age <= 4'h0;
    end else if (avm.write && avm.address == SDV_OFS_CTRL) begin
      ctrlReg <= avm.writedata;
      age <= 4'h1;
    end else if (age != 4'h0 && age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  bus_nowait_a: assert property (avm.write |-> !avmWaitrequest)
    else $error("waitrequest raised on write");
  read_one_wait_a: assert property (avmWaitrequest |=> !avmWaitrequest)
    else $error("read waited more than one cycle");
  reset_quiet_a: assert property ($fell(rst) |-> !motorEnable && !txEnable)
    else $error("outputs active after reset");
  step_single_a: assert property (motorStep.step |=> !motorStep.step)
    else $error("step longer than one cycle");
  tx_rise_a: assert property ($rose(txEnable) |-> $past(replyReq) && $past(replyReq, 2))
    else $error("driver on without reply");
  tx_drop_a: assert property (!replyReq [*3] |-> !txEnable)
    else $error("driver left on");
  gate_closed_a: assert property
    ((ok && ctrlReg.gateFn == SDV_EN_CLOSED && !gatePin) [*5] |-> !motorEnable)
    else $error("motor on while gate open");
  fault_out_a: assert property
    ((ok && ctrlReg.outFn == SDV_OUT_FAULT && faultIn) [*4] |-> outPin == !ctrlReg.outInvert)
    else $error("fault output wrong");
  out_high_a: assert property (ok && ctrlReg.outFn == SDV_OUT_NONE && avm.write
    && avm.address == SDV_OFS_OUTCMD && avm.writedata[1:0] == SDV_OCMD_HIGH |-> ##[1:3] outPin)
    else $error("output not raised");
endmodule
bind sdv_step_drive sdv_step_drive_asserts #(.CLK_HZ(CLK_HZ)) u_chk (.clk(clk), .rst(rst),
  .avm(avm), .avmWaitrequest(avmWaitrequest), .gatePin(gatePin), .faultIn(faultIn),
  .replyReq(replyReq), .txEnable(txEnable), .outPin(outPin), .motorEnable(motorEnable),
  .motorStep(motorStep));

// [test/sdv_indexer_model.sv]
// sdv_indexer_model: step pulse source facing the drive
// assumes go is a one-cycle strobe
`timescale 1ns/10ps
module sdv_indexer_model (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic go, // start burst
  input wire logic [15:0] count, // pulses
  input wire logic dirLvl, // direction
  output logic pulsePin, // step pin
  output logic dirPin, // sense pin
  output logic busy // burst on
);
  logic [15:0] left;
  logic [2:0] ph;
  assign busy = left != 16'h0;
  assign pulsePin = busy && !ph[2];
  always_ff @(posedge clk) begin
    if (rst) begin
      left <= 16'h0;
      ph <= 3'h0;
      dirPin <= 1'b0;
    end else if (go && !busy) begin
      left <= count;
      ph <= 3'h0;
      dirPin <= dirLvl;
    end else if (busy) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        left <= left - 16'h1;
      end
    end
  end
endmodule

// [test/tb_sdv_step_drive.sv]
// tb_sdv_step_drive: self-checking bench of the step drive
// assumes drive, checker and indexer model compiled first
`timescale 1ns/10ps
module tb_sdv_step_drive;
  import sdv_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sdv_avm_req_t avm = '0;
  logic avmWaitrequest, txEnable, outPin, motorEnable, busy, pulsePin, dirPin, d0;
  logic [31:0] avmReaddata, rd, r;
  logic dirLvl = 1'b0, go = 1'b0, gatePin = 1'b0, faultIn = 1'b0, replyReq = 1'b0;
  logic moving = 1'b0;
  logic [15:0] count = 16'h0, stepsRevCount;
  logic [11:0] analogSample = 12'h0;
  sdv_step_t motorStep;
  sdv_ctrl_t c;
  logic [31:0] seed = 32'd45;
  int fails = 0, total_checks = 0, nSteps = 0, n;
  sdv_step_drive dut (.clk(clk), .rst(rst), .avm(avm), .avmWaitrequest(avmWaitrequest),
    .avmReaddata(avmReaddata), .pulsePin(pulsePin), .dirPin(dirPin), .gatePin(gatePin),
    .analogSample(analogSample), .analogValid(1'b0), .faultIn(faultIn), .moving(moving),
    .replyReq(replyReq), .txEnable(txEnable), .outPin(outPin), .motorEnable(motorEnable),
    .motorStep(motorStep), .stepsRevCount(stepsRevCount));
  sdv_indexer_model idx (.clk(clk), .rst(rst), .go(go), .count(count), .dirLvl(dirLvl),
    .pulsePin(pulsePin), .dirPin(dirPin), .busy(busy));
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (motorStep.step === 1'b1) nSteps++;
  // ------
  // helpers
  // ------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd_n, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avm <= '{read: rd_n, write: !rd_n, address: a, writedata: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avmWaitrequest === 1'b0) break;
    end
    rd = avmReaddata;
    avm <= '0;
    if (i == 20) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic set_ctrl(input sdv_gate_fn_t g, input sdv_out_fn_t o);
    c = '0;
    c.mode = SDV_MODE_PULSE;
    c.gateFn = g;
    c.outFn = o;
    bus(1'b0, SDV_OFS_CTRL, c);
    repeat (8) @(posedge clk);
  endtask
  task automatic burst(input logic [15:0] np, input logic d);
    @(posedge clk);
    count <= np;
    dirLvl <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    if (n == 2000) begin
      fails++;
      complete_run();
    end
    repeat (6) @(posedge clk);
  endtask
  // ------
  // scenarios
  // ------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, SDV_OFS_STEPS_REV, 32'h0);
    chk(rd[15:0], SDV_RST_STEPS_REV);
    bus(1'b1, 8'h3c, 32'h0);
    chk(rd, SDV_UNMAPPED);
    $display("done: reset");
    set_ctrl(SDV_EN_NONE, SDV_OUT_NONE);
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      @(posedge clk);
      gatePin <= r[0];
      analogSample <= r[15:4];
      repeat (4) @(posedge clk);
      bus(1'b1, SDV_OFS_STATUS, 32'h0);
      chk(rd[2], r[0]);
      r[1:0] = 2'(k % 3);
      bus(1'b0, SDV_OFS_OUTCMD, r & 32'h13);
      repeat (3) @(posedge clk);
      chk(outPin, r[1:0] == SDV_OCMD_HIGH || (r[1:0] == SDV_OCMD_DRIVE && r[4]));
    end
    $display("done: status and output commands");
    for (int k = 0; k < 4; k++) begin
      set_ctrl(k[1] ? SDV_EN_OPEN : SDV_EN_CLOSED, SDV_OUT_NONE);
      @(posedge clk);
      gatePin <= k[0];
      repeat (6) @(posedge clk);
      chk(motorEnable, k[0] ^ k[1]);
    end
    $display("done: gate enable");
    set_ctrl(SDV_EN_NONE, SDV_OUT_NONE);
    bus(1'b0, SDV_OFS_STEPS_REV, 32'h5);
    nSteps = 0;
    burst(16'd10, 1'b0);
    chk(stepsRevCount, 16'h0);
    d0 = motorStep.dirCw;
    burst(16'd3, 1'b1);
    chk(stepsRevCount, 16'h3);
    chk(nSteps, 13);
    chk(motorStep.dirCw, !d0);
    $display("done: steps per revolution");
    set_ctrl(SDV_EN_RST_CLOSE, SDV_OUT_FAULT);
    @(posedge clk);
    gatePin <= 1'b0;
    faultIn <= 1'b1;
    repeat (6) @(posedge clk);
    faultIn <= 1'b0;
    repeat (4) @(posedge clk);
    chk(outPin, 1'b1);
    bus(1'b1, SDV_OFS_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    @(posedge clk);
    gatePin <= 1'b1;
    repeat (6) @(posedge clk);
    chk(outPin, 1'b0);
    set_ctrl(SDV_EN_NONE, SDV_OUT_MOTION);
    @(posedge clk);
    moving <= 1'b1;
    repeat (3) @(posedge clk);
    chk(outPin, 1'b1);
    $display("done: fault and alarm reset");
    bus(1'b0, SDV_OFS_SERIAL, {16'h0001, 8'h00, SDV_RST_ADDR});
    bus(1'b1, SDV_OFS_SERIAL, 32'h0);
    chk(rd, {16'h0001, 8'h00, SDV_RST_ADDR});
    @(posedge clk);
    replyReq <= 1'b1;
    for (n = 0; n < 30000; n++) begin
      @(posedge clk);
      if (txEnable === 1'b1) break;
    end
    chk(n >= SDV_CYC_PER_MS - 1 && n <= SDV_CYC_PER_MS + 3, 1'b1);
    if (n == 30000) complete_run();
    @(posedge clk);
    replyReq <= 1'b0;
    repeat (4) @(posedge clk);
    chk(txEnable, 1'b0);
    $display("done: transmit delay");
    bus(1'b0, SDV_OFS_ACCEL, 32'hffff);
    bus(1'b0, SDV_OFS_SPEED, 32'hf000);
    c = '0;
    c.mode = SDV_MODE_VEL;
    bus(1'b0, SDV_OFS_CTRL, c);
    nSteps = 0;
    repeat (30000) @(posedge clk);
    bus(1'b1, SDV_OFS_STATUS, 32'h0);
    chk(rd[31:16], 16'hf000);
    chk(nSteps > 0, 1'b1);
    $display("done: velocity");
    complete_run();
  end
endmodule
